// ### latched_read_remote_access.sv
// latched read remote access machine with axi4-lite control registers
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module latched_read_remote_access #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // remote side
    input wire logic remote_access_enable_in,
    input wire logic remote_read_strobe_n_in,
    input wire logic reg_select_in,
    input wire logic wait_n_in,
    output logic transfer_ack_out,
    output logic local_ownership_out,
    // local timing unit
    input wire logic lock_in,
    input wire logic local_bus_request_in,
    output logic local_bus_grant_out,
    output logic local_wait_out,
    // memory buses
    input wire logic [15:0] instr_word_in,
    input wire logic [7:0] remote_ctrl_data_in,
    output logic mem_read_n_out,
    output logic [7:0] data_bus_out,
    output logic data_bus_oe_out,
    output logic addr_bus_oe_out
);
    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    latched_read_pkg::fsm_e state_q;
    latched_read_pkg::fsm_e state_d;
    logic [31:0] ctrl_q;
    logic [15:0] pc_q;
    logic high_byte_flag_q;
    logic [1:0] iw_cnt_q;
    logic [2:0] dw_cnt_q;
    logic [1:0] target_q;
    logic is_reg_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    wire logic rd_req = remote_access_enable_in & ~remote_read_strobe_n_in;
    wire logic lock_out_remote = ctrl_q[latched_read_pkg::ctrl_lor_bit];
    wire logic [1:0] memory_select = ctrl_q[latched_read_pkg::ctrl_ms_lo +: 2];
    wire logic [1:0] instr_wait_count = ctrl_q[latched_read_pkg::ctrl_iw_lo +: 2];
    wire logic [2:0] data_wait_count = ctrl_q[latched_read_pkg::ctrl_dw_lo +: 3];
    wire logic is_data = ~is_reg_q & (target_q == latched_read_pkg::ms_data);
    wire logic is_instr = ~is_reg_q & (target_q == latched_read_pkg::ms_instr);
    wire logic waits_done = is_data ? (dw_cnt_q == 3'h0) : (is_instr ? (iw_cnt_q == 2'h0) : 1'b1);
    wire logic idle = (state_q == latched_read_pkg::st_idle1) |
        (state_q == latched_read_pkg::st_idle2);
    wire logic busy_local = lock_out_remote | local_bus_grant_out;

    // -------------------------------------------------------------
    // state machine
    // -------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            latched_read_pkg::st_idle1: begin
                if (rd_req && busy_local) begin
                    state_d = latched_read_pkg::st_idle2;
                end else if (rd_req && !local_bus_request_in) begin
                    state_d = latched_read_pkg::st_take;
                end
            end
            latched_read_pkg::st_idle2: begin
                if (!rd_req) begin
                    state_d = latched_read_pkg::st_idle1;
                end else if (!busy_local && !local_bus_request_in) begin
                    state_d = latched_read_pkg::st_take;
                end
            end
            latched_read_pkg::st_take: state_d = latched_read_pkg::st_setup;
            latched_read_pkg::st_setup: state_d = latched_read_pkg::st_access;
            latched_read_pkg::st_access: begin
                if (waits_done && wait_n_in) begin
                    state_d = latched_read_pkg::st_term;
                end
            end
            latched_read_pkg::st_term: state_d = latched_read_pkg::st_release;
            latched_read_pkg::st_release: begin
                state_d = rd_req ? latched_read_pkg::st_final : latched_read_pkg::st_idle1;
            end
            latched_read_pkg::st_final: begin
                if (!rd_req) begin
                    state_d = latched_read_pkg::st_idle1;
                end
            end
            default: state_d = latched_read_pkg::st_idle1;
        endcase
    end

    // byte offered on the data bus for the access in progress
    wire logic [7:0] access_byte = is_reg_q ? remote_ctrl_data_in :
        (target_q == latched_read_pkg::ms_pc_lo) ? pc_q[7:0] :
        (target_q == latched_read_pkg::ms_pc_hi) ? pc_q[15:8] :
        high_byte_flag_q ? instr_word_in[15:8] : instr_word_in[7:0];
    wire logic wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid_out;
    wire logic ms_write_instr = wr_fire && (aw_addr_q == latched_read_pkg::ctrl_off) &&
        w_strb_q[0] && (w_data_q[latched_read_pkg::ctrl_ms_lo +: 2] == latched_read_pkg::ms_instr);
    wire logic end_instr = (state_q == latched_read_pkg::st_release) && is_instr;

    // -------------------------------------------------------------
    // axi4-lite slave
    // -------------------------------------------------------------
    wire logic wr_ok = (aw_addr_q == latched_read_pkg::ctrl_off);
    wire logic [31:0] rd_word = (s_axi_araddr_in == latched_read_pkg::ctrl_off) ? ctrl_q :
        (s_axi_araddr_in == latched_read_pkg::status_off) ?
        {27'h0, high_byte_flag_q, state_q} :
        (s_axi_araddr_in == latched_read_pkg::pc_off) ? {16'h0, pc_q} : 32'h0000_0000;
    wire logic rd_ok = (s_axi_araddr_in == latched_read_pkg::ctrl_off) ||
        (s_axi_araddr_in == latched_read_pkg::status_off) ||
        (s_axi_araddr_in == latched_read_pkg::pc_off);
    logic [31:0] ctrl_merge;
    always_comb begin
        ctrl_merge = ctrl_q;
        for (int i = 0; i < 4; i++) begin
            if (w_strb_q[i]) begin
                ctrl_merge[i*8 +: 8] = w_data_q[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= latched_read_pkg::resp_okay;
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= latched_read_pkg::resp_okay;
            ctrl_q <= latched_read_pkg::ctrl_reset;
        end else begin
            s_axi_awready_out <= !aw_hold_q && !s_axi_awready_out && s_axi_awvalid_in;
            s_axi_wready_out <= !w_hold_q && !s_axi_wready_out && s_axi_wvalid_in;
            if (s_axi_awready_out && s_axi_awvalid_in) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
            end
            if (s_axi_wready_out && s_axi_wvalid_in) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_ok ? latched_read_pkg::resp_okay :
                    latched_read_pkg::resp_slverr;
                if (wr_ok) begin
                    ctrl_q <= ctrl_merge;
                end
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
            s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && s_axi_arvalid_in;
            if (s_axi_arready_out && s_axi_arvalid_in) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_word;
                s_axi_rresp_out <= rd_ok ? latched_read_pkg::resp_okay :
                    latched_read_pkg::resp_slverr;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // access bookkeeping
    // -------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state_q <= latched_read_pkg::st_idle1;
            pc_q <= latched_read_pkg::pc_reset;
            high_byte_flag_q <= 1'b0;
            iw_cnt_q <= 2'h0;
            dw_cnt_q <= 3'h0;
            target_q <= latched_read_pkg::ms_data;
            is_reg_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == latched_read_pkg::st_take) begin
                target_q <= memory_select;
                is_reg_q <= reg_select_in;
            end
            if (state_q == latched_read_pkg::st_setup) begin
                iw_cnt_q <= instr_wait_count;
                dw_cnt_q <= data_wait_count;
            end else if (state_q == latched_read_pkg::st_access) begin
                if (iw_cnt_q != 2'h0) begin
                    iw_cnt_q <= iw_cnt_q - 2'h1;
                end
                if (dw_cnt_q != 3'h0) begin
                    dw_cnt_q <= dw_cnt_q - 3'h1;
                end
            end
            // a control write of 01 realigns even if an access ends now
            if (ms_write_instr) begin
                high_byte_flag_q <= 1'b0;
            end else if (end_instr) begin
                high_byte_flag_q <= ~high_byte_flag_q;
            end
            if (end_instr && high_byte_flag_q) begin
                pc_q <= pc_q + 16'h0001;
            end
        end
    end

    // -------------------------------------------------------------
    // pin drive; one clock late so access actions hold into the next state, save ownership and ack, which follow state_d
    // -------------------------------------------------------------
    wire logic in_access = (state_q == latched_read_pkg::st_access);
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            transfer_ack_out <= 1'b1;
            local_ownership_out <= 1'b0;
            local_bus_grant_out <= 1'b0;
            local_wait_out <= 1'b0;
            mem_read_n_out <= 1'b1;
            data_bus_out <= 8'h00;
            data_bus_oe_out <= 1'b0;
            addr_bus_oe_out <= 1'b0;
        end else begin
            transfer_ack_out <= !(rd_req && (idle || state_d != latched_read_pkg::st_term) &&
                state_q != latched_read_pkg::st_term && state_q != latched_read_pkg::st_release &&
                state_q != latched_read_pkg::st_final) || state_d == latched_read_pkg::st_term;
            local_ownership_out <= (state_d == latched_read_pkg::st_setup) ||
                (state_d == latched_read_pkg::st_access) ||
                (state_d == latched_read_pkg::st_term);
            local_bus_grant_out <= (idle && state_d != latched_read_pkg::st_take && lock_in &&
                local_bus_request_in) || (((state_q == latched_read_pkg::st_release) ||
                (state_q == latched_read_pkg::st_final)) && local_bus_request_in);
            local_wait_out <= !idle && state_q != latched_read_pkg::st_term &&
                state_q != latched_read_pkg::st_release && state_q != latched_read_pkg::st_final &&
                local_bus_request_in;
            mem_read_n_out <= !(in_access && is_data);
            data_bus_out <= in_access ? access_byte : remote_ctrl_data_in;
            data_bus_oe_out <= !(state_q == latched_read_pkg::st_take ||
                state_q == latched_read_pkg::st_setup || state_q == latched_read_pkg::st_term) &&
                !(in_access && is_data);
            addr_bus_oe_out <= !(state_q == latched_read_pkg::st_take ||
                state_q == latched_read_pkg::st_setup || in_access ||
                state_q == latched_read_pkg::st_term);
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    property p_idle_hold;
        @(posedge clock_in) disable iff (!nrst_in)
        (state_q == latched_read_pkg::st_idle1 && !rd_req) |=>
        state_q == latched_read_pkg::st_idle1;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle left without request");
    property p_lockout;
        @(posedge clock_in) disable iff (!nrst_in)
        (idle && rd_req && lock_out_remote) |=> state_q == latched_read_pkg::st_idle2;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lock-out ignored");
    property p_ack_low;
        @(posedge clock_in) disable iff (!nrst_in)
        (idle && rd_req) |=> !transfer_ack_out;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack not low on request");
    sequence s_take_setup;
        state_q == latched_read_pkg::st_take ##1 state_q == latched_read_pkg::st_setup;
    endsequence
    property p_take;
        @(posedge clock_in) disable iff (!nrst_in)
        (state_q == latched_read_pkg::st_idle1 && rd_req && !busy_local &&
        !local_bus_request_in) |=> s_take_setup;
    endproperty
    a_take: assert property (p_take) else $error("takeover sequence wrong");
    property p_own;
        @(posedge clock_in) disable iff (!nrst_in)
        state_q == latched_read_pkg::st_setup |=> local_ownership_out && !transfer_ack_out;
    endproperty
    a_own: assert property (p_own) else $error("ownership not raised");
    property p_term_ack;
        @(posedge clock_in) disable iff (!nrst_in)
        state_q == latched_read_pkg::st_term |-> transfer_ack_out && local_ownership_out;
    endproperty
    a_term_ack: assert property (p_term_ack) else $error("ack not high in termination");
    property p_wait_ext;
        @(posedge clock_in) disable iff (!nrst_in)
        (in_access && !wait_n_in) |=> state_q == latched_read_pkg::st_access;
    endproperty
    a_wait_ext: assert property (p_wait_ext) else $error("wait extension ignored");
    property p_no_grant;
        @(posedge clock_in) disable iff (!nrst_in)
        (state_q == latched_read_pkg::st_setup) |-> !local_bus_grant_out;
    endproperty
    a_no_grant: assert property (p_no_grant) else $error("grant during access");
    property p_release;
        @(posedge clock_in) disable iff (!nrst_in)
        (state_q == latched_read_pkg::st_release && !rd_req) |=>
        state_q == latched_read_pkg::st_idle1 && !local_ownership_out;
    endproperty
    a_release: assert property (p_release) else $error("release did not return idle");
    property p_rd_strobe;
        @(posedge clock_in) disable iff (!nrst_in)
        (in_access && is_data) |=> !mem_read_n_out && !data_bus_oe_out;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");
    property p_pc_byte;
        @(posedge clock_in) disable iff (!nrst_in)
        (in_access && !is_reg_q && target_q == latched_read_pkg::ms_pc_lo) |=>
        data_bus_out == pc_q[7:0];
    endproperty
    a_pc_byte: assert property (p_pc_byte) else $error("pc low byte not driven");
    property p_own_drop;
        @(posedge clock_in) disable iff (!nrst_in)
        state_q == latched_read_pkg::st_term |=> !local_ownership_out && !addr_bus_oe_out;
    endproperty
    a_own_drop: assert property (p_own_drop) else $error("ownership not dropped");
    property p_realign;
        @(posedge clock_in) disable iff (!nrst_in)
        ms_write_instr |=> !high_byte_flag_q;
    endproperty
    a_realign: assert property (p_realign) else $error("high byte flag not cleared");
    property p_flag_toggle;
        @(posedge clock_in) disable iff (!nrst_in)
        (end_instr && !ms_write_instr) |=> high_byte_flag_q != $past(high_byte_flag_q);
    endproperty
    a_flag_toggle: assert property (p_flag_toggle) else $error("high byte flag not toggled");
endmodule

// ### latched_read_pkg.sv
// shared constants for the latched read remote access block
package latched_read_pkg;
    // -------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [3:0] ctrl_off = 4'h0;
    localparam logic [3:0] status_off = 4'h4;
    localparam logic [3:0] pc_off = 4'h8;
    // -------------------------------------------------------------
    // control register fields
    // -------------------------------------------------------------
    localparam int ctrl_lor_bit = 0;
    localparam int ctrl_ms_lo = 1;
    localparam int ctrl_iw_lo = 4;
    localparam int ctrl_dw_lo = 8;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [1:0] ms_data = 2'h0;
    localparam logic [1:0] ms_instr = 2'h1;
    localparam logic [1:0] ms_pc_lo = 2'h2;
    localparam logic [1:0] ms_pc_hi = 2'h3;
    localparam logic [15:0] pc_reset = 16'h0000;
    // -------------------------------------------------------------
    // axi responses
    // -------------------------------------------------------------
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // -------------------------------------------------------------
    // machine states
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        st_idle1 = 4'h0,
        st_idle2 = 4'h1,
        st_take = 4'h2,
        st_setup = 4'h3,
        st_access = 4'h4,
        st_term = 4'h5,
        st_release = 4'h6,
        st_final = 4'h7
    } fsm_e;
endpackage

// ### remote_host_model.sv
// remote host processor model issuing latched reads
`timescale 1ns/100ps
module remote_host_model (
    // clock and command
    input wire logic clock_in,
    input wire logic go_in,
    input wire logic sel_in,
    input wire logic [7:0] stall_in,
    // device side
    input wire logic transfer_ack_in,
    input wire logic local_ownership_in,
    output logic remote_access_enable_out,
    output logic remote_read_strobe_n_out,
    output logic reg_select_out,
    output logic wait_n_out,
    output logic busy_out
);
    logic [7:0] held_q = 8'h00;
    logic seen_q = 1'b0;
    initial begin
        remote_access_enable_out = 1'b0;
        remote_read_strobe_n_out = 1'b1;
        reg_select_out = 1'b0;
        wait_n_out = 1'b1;
        busy_out = 1'b0;
    end
    always @(posedge clock_in) begin
        if (!busy_out) begin
            // an unselected line must not keep showing its last value
            reg_select_out <= ~reg_select_out;
            if (go_in) begin
                remote_access_enable_out <= 1'b1;
                remote_read_strobe_n_out <= 1'b0;
                reg_select_out <= sel_in;
                wait_n_out <= (stall_in == 8'h00);
                held_q <= 8'h00;
                seen_q <= 1'b0;
                busy_out <= 1'b1;
            end
        end else begin
            if (!transfer_ack_in) seen_q <= 1'b1;
            if (local_ownership_in && held_q != stall_in) begin
                held_q <= held_q + 8'h01;
                wait_n_out <= (held_q + 8'h01 == stall_in);
            end
            if (transfer_ack_in && seen_q) begin
                remote_read_strobe_n_out <= 1'b1;
                remote_access_enable_out <= 1'b0;
                wait_n_out <= 1'b1;
                busy_out <= 1'b0;
            end
        end
    end
endmodule

// ### latched_read_remote_access_tb.sv
// self-checking bench for the latched read remote access block
`timescale 1ns/100ps
module latched_read_remote_access_tb;
    logic clock_in = 1'b0, nrst_in = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, ack, own, grant, lwait, rd_n, doe, aoe;
    logic [1:0] bresp, rresp, rs, bs;
    logic remote_access_enable, rrs_n, rsel, wait_n, busy, go = 1'b0, sel = 1'b0, lock = 1'b0, lbr = 1'b0;
    logic [7:0] stall = 8'h00, dbus, got;
    logic [15:0] iword = 16'h5AC3;
    logic [7:0] rcd = 8'h96;
    int miscompares = 0, samples_checked = 0, cycles = 0, lowcnt, l0, bad_grant = 0;
    int bad_float = 0, lw_seen = 0;
    logic rd_seen, goe;
    always #20 clock_in = ~clock_in;
    latched_read_remote_access DUT (.clock_in(clock_in), .nrst_in(nrst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .remote_access_enable_in(remote_access_enable), .remote_read_strobe_n_in(rrs_n), .reg_select_in(rsel),
        .wait_n_in(wait_n), .transfer_ack_out(ack), .local_ownership_out(own),
        .lock_in(lock), .local_bus_request_in(lbr), .local_bus_grant_out(grant),
        .local_wait_out(lwait), .instr_word_in(iword), .remote_ctrl_data_in(rcd),
        .mem_read_n_out(rd_n), .data_bus_out(dbus), .data_bus_oe_out(doe),
        .addr_bus_oe_out(aoe));
    remote_host_model HOST (.clock_in(clock_in), .go_in(go), .sel_in(sel),
        .stall_in(stall), .transfer_ack_in(ack), .local_ownership_in(own),
        .remote_access_enable_out(remote_access_enable), .remote_read_strobe_n_out(rrs_n),
        .reg_select_out(rsel), .wait_n_out(wait_n), .busy_out(busy));
    task automatic complete_run;
        if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            miscompares++;
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        logic done = 1'b0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(posedge clock_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        // one quiet edge so a following call never re-drives a strobe in this step
        @(posedge clock_in);
    endtask
    task automatic rdr(logic [3:0] a);
        logic done = 1'b0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge clock_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge clock_in);
    endtask
    // one remote read; data latched at the edge where ack is first seen high again
    task automatic rr(logic s, logic [7:0] st);
        logic was_low = 1'b0;
        sel <= s; stall <= st; go <= 1'b1; lowcnt = 0; rd_seen = 1'b0;
        @(posedge clock_in);
        go <= 1'b0;
        while (busy || go) begin
            @(posedge clock_in);
            if (!ack) begin lowcnt++; was_low = 1'b1; end
            else if (was_low && busy) begin
                got = dbus;
                goe = doe;
            end
            if (!rd_n) rd_seen = 1'b1;
            if ((own && aoe) || (!rd_n && doe)) bad_float++;
            if (lwait) lw_seen++;
            if (own) lbr <= 1'b1;
            if (own && grant) bad_grant++;
        end
        lbr <= 1'b0;
        repeat (4) @(posedge clock_in);
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles > 20000) begin miscompares++; complete_run(); end
    end
    initial begin
        repeat (10) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
        check("ack", 1, ack);
        check("own", 0, own);
        rdr(4'h0); check("ctrl", latched_read_pkg::ctrl_reset, rd);
        check("aoe idle", 1, aoe);
        rdr(4'hC); check("rresp", latched_read_pkg::resp_slverr, rs);
        wr(4'hC, 32'h0000_0001); check("bresp", latched_read_pkg::resp_slverr, bs);
        rdr(4'h0); check("ctrl kept", latched_read_pkg::ctrl_reset, rd);
        lock <= 1'b1; lbr <= 1'b1;
        repeat (3) @(posedge clock_in);
        check("grant", 1, grant);
        lbr <= 1'b0;
        repeat (3) @(posedge clock_in);
        // lock-out set: request must stall in the second idle state
        wr(4'h0, 32'h0000_0007);
        check("bresp ok", latched_read_pkg::resp_okay, bs);
        sel <= 1'b0; stall <= 8'h00; go <= 1'b1;
        @(posedge clock_in); go <= 1'b0;
        repeat (8) @(posedge clock_in);
        check("ack held", 0, ack);
        check("own idle2", 0, own);
        rdr(4'h4); check("state", latched_read_pkg::st_idle2, rd[3:0]);
        wr(4'h0, 32'h0000_0006);
        // the byte stands only in the cycle where the acknowledge is back high
        while (busy) begin
            @(posedge clock_in);
            if (ack && busy) got = dbus;
        end
        check("pc hi", 8'h00, got);
        repeat (4) @(posedge clock_in);
        wr(4'h0, 32'h0000_0022);
        for (int i = 0; i < 2; i++) begin
            rr(1'b0, 8'h00); check("instr", iword[8*i+:8], got);
            check("instr oe", 1, goe);
            rdr(4'h4); check("flag", i == 0, rd[4]);
        end
        rdr(4'h8); check("pc", 16'h0001, rd[15:0]);
        rr(1'b0, 8'h00);
        wr(4'h0, 32'h0000_0022);
        rdr(4'h4); check("flag realign", 0, rd[4]);
        wr(4'h0, 32'h0000_0004);
        rr(1'b0, 8'h00); check("pc lo", 8'h01, got);
        rr(1'b1, 8'h00); check("ctrl byte", rcd, got);
        wr(4'h0, 32'h0000_0300);
        rr(1'b0, 8'h00); l0 = lowcnt;
        check("read strobe", 1, rd_seen);
        check("data float", 0, goe);
        rr(1'b0, 8'd20);
        check("extend", 1, lowcnt >= l0 + 10);
        check("no grant", 0, bad_grant);
        check("float", 0, bad_float);
        check("local wait", 1, lw_seen > 0);
        complete_run();
    end
endmodule
